// ==== hw/fba_cksum.sv ====
// Expected block checksum: all ones minus the byte sum of the buffer.
// Assumes the buffer is presented flat, byte 0 in the low bits.
`timescale 1ns/1ps
module fba_cksum
  import fba_pkg::*;
(
  input wire logic [255:0] bytes_i,
  output logic [7:0] expect_o
);
  logic [7:0] part [0:BLK_BYTES];

  // Running byte sum, carries above bit 7 dropped
  assign part[0] = 8'h00;
  genvar g;
  generate
    for (g = 0; g < BLK_BYTES; g = g + 1)
    begin : g_sum
      assign part[g+1] = part[g] + bytes_i[8*g +: 8];
    end
  endgenerate

  // (R24) Complement of the sum
  assign expect_o = CKS_BASE - part[BLK_BYTES];
endmodule

// ==== hw/fba_keyseq.sv ====
// Security level tracker driven by control words and key pairs.
// Assumes a control word arrives as a one-cycle pulse with its value.
`timescale 1ns/1ps
module fba_keyseq
  import fba_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic word_v_i,
  input wire logic [15:0] word_i,
  input wire logic [31:0] unseal_key_i,
  input wire logic [31:0] full_key_i,
  output logic sealed_o,
  output logic full_o,
  output logic fas_o
);
  fba_sec_e state_q, state_d;
  logic half_q, half_d;
  logic which_q, which_d;
  logic second_ok;

  // Keys are sent with their two bytes swapped
  function automatic logic [15:0] swap(input logic [15:0] w);
    swap = {w[7:0], w[15:8]};
  endfunction

  // ------------------------------------------------------------
  // Key sequence
  // ------------------------------------------------------------
  // (R23) Key 1 first, then key 0
  assign second_ok = half_q && (word_i == swap(which_q ? full_key_i[31:16]
                                                       : unseal_key_i[31:16]));
  always_comb
  begin
    state_d = state_q;
    half_d = half_q;
    which_d = which_q;
    if (word_v_i)
    begin
      // (R19) Pair must be back to back
      half_d = 1'b0;
      if (second_ok)
      begin
        // (R21) Unseal pair clears sealed
        if (!which_q && state_q == SEC_SEALED)
          state_d = SEC_UNSEALED;
        // (R22) Full pair clears full flag
        else if (which_q && state_q == SEC_UNSEALED)
          state_d = SEC_FULL;
      end
      else if (word_i == SEAL_SUBCMD)
        state_d = SEC_SEALED;
      else if (word_i == swap(unseal_key_i[15:0]))
      begin
        half_d = 1'b1;
        which_d = 1'b0;
      end
      else if (word_i == swap(full_key_i[15:0]))
      begin
        half_d = 1'b1;
        which_d = 1'b1;
      end
      // (R27) Wrong word restarts detection
    end
  end

  // State and flags
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      state_q <= SEC_SEALED;
      half_q <= 1'b0;
      which_q <= 1'b0;
      sealed_o <= 1'b1;
      full_o <= 1'b0;
      fas_o <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      half_q <= half_d;
      which_q <= which_d;
      sealed_o <= (state_d == SEC_SEALED);
      full_o <= (state_d == SEC_FULL);
      fas_o <= (state_d != SEC_FULL);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_unseal_pair_ok: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R21
    word_v_i && second_ok && !which_q && sealed_o |=> !sealed_o && fas_o)
    else $error("unseal pair did not clear sealed flag");
  a_full_pair_ok: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R22
    word_v_i && second_ok && which_q && state_q == SEC_UNSEALED |=> !fas_o)
    else $error("full access pair did not clear flag");
  a_bad_pair_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R27
    word_v_i && !second_ok && word_i != SEAL_SUBCMD |=> $stable(state_q))
    else $error("wrong key changed security level");
endmodule

// ==== hw/fba_pkg.sv ====
// Constants for the block access and security logic.
// Assumes a single 200 MHz clock and byte-wide command accesses.
package fba_pkg;
  // ------------------------------------------------------------
  // Command addresses
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_CTL_LO = 8'h00;
  localparam logic [7:0] CMD_CTL_HI = 8'h01;
  localparam logic [7:0] CMD_SUB = 8'h3e;
  localparam logic [7:0] CMD_BLK = 8'h3f;
  localparam logic [7:0] CMD_BUF_LO = 8'h40;
  localparam logic [7:0] CMD_BUF_HI = 8'h5f;
  localparam logic [7:0] CMD_CKS = 8'h60;
  localparam logic [7:0] CMD_DCTL = 8'h61;
  localparam logic [7:0] CMD_LEN = 8'h62;
  localparam logic [7:0] CMD_LBL_LO = 8'h63;
  localparam logic [7:0] CMD_LBL_HI = 8'h6c;
  // ------------------------------------------------------------
  // Storage layout
  // ------------------------------------------------------------
  localparam int BLK_BYTES = 32;
  localparam logic [5:0] BLK_BYTES_C = 6'h20;
  localparam int NV_SLOTS = 32;
  localparam logic [7:0] SUB_VENDOR = 8'h3a;
  localparam logic [7:0] SUB_KEYS = 8'h70;
  localparam logic [7:0] DCTL_GENERAL = 8'h00;
  localparam logic [7:0] VEND_SEL_A = 8'h01;
  localparam logic [7:0] VEND_SEL_B = 8'h02;
  localparam logic [4:0] SLOT_VEND_A = 5'h00;
  localparam logic [4:0] SLOT_VEND_B = 5'h01;
  localparam logic [7:0] CKS_BASE = 8'hff;
  // ------------------------------------------------------------
  // Control status word and security
  // ------------------------------------------------------------
  localparam int STAT_SS_BIT = 13;
  localparam int STAT_FAS_BIT = 14;
  localparam logic [15:0] SEAL_SUBCMD = 16'h0020;
  localparam logic [31:0] UNSEAL_KEY_RST = 32'h36720414;
  localparam logic [31:0] FULL_KEY_RST = 32'hffffffff;
  // Arbitrary part label, not tied to any real product
  localparam logic [7:0] LABEL_LEN = 8'h0a;
  localparam logic [79:0] LABEL_CHARS = 80'h67617567655f626c6b31;
  typedef enum logic [1:0] {
    SEC_SEALED = 2'b00,
    SEC_UNSEALED = 2'b01,
    SEC_FULL = 2'b11
  } fba_sec_e;
endpackage

// ==== hw/fba_top.sv ====
// Block access to non-volatile storage with checksum commit and
// three-level key security, reached by byte command reads and writes.
// Assumes host command strobes are synchronous one-cycle pulses.
`timescale 1ns/1ps
// Function
// (R1) Control 0x00 selects general storage when unsealed
// (R2) Sealed: control byte writes refused
// (R3) 0x62 returns label length, always readable
// (R4) 0x63-0x6c return label characters
// (R5) 32-byte block exposed at 0x40-0x5f
// (R6) Single buffer bytes readable and writable
// (R7) Commit only after correct checksum write
// (R8) Subclass first, then block select loads
// (R9) Host computes block and buffer offset
// (R10) Overlong block write is discarded
// (R11) No range check; storage survives reset
// (R12) Two 32-byte vendor blocks A, B
// (R13) Vendor B is subclass 58 block 1
// (R14) Vendor mode: select 1/2 loads A/B
// (R15) Vendor mode commits after valid checksum
// (R16) Sealed: vendor A not writable
// (R17) Sealed: general storage denied
// (R18) Only full access writes stored keys
// (R19) Key words must be back to back
// (R20) Host keys differ from subcommand codes
// (R21) Sealed flag clears on unseal pair
// (R22) Full flag clears on full pair
// (R23) Key 1 first, bytes swapped
// (R24) Checksum is 255 minus byte sum
// (R25) Keys travel through control word 0x00/0x01
// (R26) Wrong checksum leaves storage unchanged
// (R27) Wrong key pair keeps level, restarts
module fba_top
  import fba_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic cmd_first_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic [7:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  output logic commit_o,
  output logic sealed_o,
  output logic full_access_flag_o
);
  logic [7:0] subclass_select_q;
  logic [7:0] block_select_q;
  logic [7:0] block_access_control_q;
  logic [7:0] block_checksum_q;
  logic [7:0] ctl_lo_q;
  logic [7:0] block_buffer_q [0:BLK_BYTES-1];
  logic [7:0] nv_q [0:NV_SLOTS-1][0:BLK_BYTES-1];
  logic [4:0] slot_q, slot_d;
  logic slot_ok_q, slot_ok_d;
  logic tgt_gen_q, tgt_key_q;
  logic discard_q;
  logic [5:0] burst_q;
  logic [31:0] unseal_key_q, full_key_q;
  logic [255:0] buf_flat;
  logic [7:0] cks_expect;
  logic [7:0] rd_mux;
  logic full_q;
  logic gen_mode, wr_buf, wr_blk, wr_cks, overflow, commit_ok;

  // Buffer range decode, used by reads and writes
  function automatic logic in_buf(input logic [7:0] a);
    in_buf = (a >= CMD_BUF_LO) && (a <= CMD_BUF_HI);
  endfunction

  // Storage slot of a subclass and block; subclass 58 holds A and B
  function automatic logic [4:0] gen_slot(input logic [7:0] s, input logic [7:0] b);
    // (R13) Vendor B at subclass 58 block 1
    if (s == SUB_VENDOR)
      gen_slot = {4'h0, b[0]};
    else
      gen_slot = {1'b1, s[2:0], b[0]};
  endfunction

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  fba_cksum u_cksum (
    .bytes_i(buf_flat),
    .expect_o(cks_expect)
  );

  // (R25) Control word taken on high byte write
  fba_keyseq u_keyseq (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .word_v_i(cmd_wr_i && cmd_addr_i == CMD_CTL_HI),
    .word_i({cmd_wdata_i, ctl_lo_q}),
    .unseal_key_i(unseal_key_q),
    .full_key_i(full_key_q),
    .sealed_o(sealed_o),
    .full_o(full_q),
    .fas_o(full_access_flag_o)
  );

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < BLK_BYTES; g = g + 1)
    begin : g_flat
      assign buf_flat[8*g +: 8] = block_buffer_q[g];
    end
  endgenerate

  // (R1) General mode needs unsealed and control zero
  assign gen_mode = !sealed_o && block_access_control_q == DCTL_GENERAL;
  assign wr_buf = cmd_wr_i && in_buf(cmd_addr_i);
  assign wr_blk = cmd_wr_i && cmd_addr_i == CMD_BLK;
  assign wr_cks = cmd_wr_i && cmd_addr_i == CMD_CKS;
  // (R10) Byte beyond 32 in one write
  assign overflow = wr_buf && !cmd_first_i && burst_q == BLK_BYTES_C;
  // (R7) (R16) (R17) (R18) (R26) Commit permission
  assign commit_ok = wr_cks && cmd_wdata_i == cks_expect && slot_ok_q && !discard_q
                     && !(sealed_o && (tgt_gen_q || slot_q == SLOT_VEND_A))
                     && !(tgt_key_q && !full_q);

  // Target slot chosen by the block select value
  always_comb
  begin
    slot_d = slot_q;
    slot_ok_d = 1'b0;
    if (gen_mode)
    begin
      // (R8) Block within the selected subclass
      slot_d = gen_slot(subclass_select_q, cmd_wdata_i);
      slot_ok_d = 1'b1;
    end
    // (R14) Vendor mode picks A or B
    else if (cmd_wdata_i == VEND_SEL_A || cmd_wdata_i == VEND_SEL_B)
    begin
      slot_d = (cmd_wdata_i == VEND_SEL_A) ? SLOT_VEND_A : SLOT_VEND_B;
      slot_ok_d = 1'b1;
    end
  end

  // Selects, control byte, checksum and control low byte
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      subclass_select_q <= 8'h00;
      block_select_q <= 8'h00;
      block_access_control_q <= 8'h00;
      block_checksum_q <= 8'h00;
      ctl_lo_q <= 8'h00;
      slot_q <= 5'h00;
      slot_ok_q <= 1'b0;
      tgt_gen_q <= 1'b0;
      tgt_key_q <= 1'b0;
    end
    else if (cmd_wr_i)
    begin
      if (cmd_addr_i == CMD_CTL_LO)
        ctl_lo_q <= cmd_wdata_i;
      // (R17) Subclass select refused when sealed
      if (cmd_addr_i == CMD_SUB && !sealed_o)
        subclass_select_q <= cmd_wdata_i;
      // (R2) Control byte refused when sealed
      if (cmd_addr_i == CMD_DCTL && !sealed_o)
        block_access_control_q <= cmd_wdata_i;
      if (wr_cks)
        block_checksum_q <= cmd_wdata_i;
      if (wr_blk)
      begin
        block_select_q <= cmd_wdata_i;
        slot_q <= slot_d;
        slot_ok_q <= slot_ok_d;
        tgt_gen_q <= gen_mode;
        tgt_key_q <= gen_mode && subclass_select_q == SUB_KEYS && cmd_wdata_i == 8'h00;
      end
    end
  end

  // Burst length count and discard flag
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      burst_q <= 6'h00;
      discard_q <= 1'b0;
    end
    else
    begin
      if (cmd_wr_i && cmd_first_i)
        burst_q <= in_buf(cmd_addr_i) ? 6'h01 : 6'h00;
      else if (wr_buf && !overflow)
        burst_q <= burst_q + 6'h01;
      // (R10) Discard until the next block select
      if (wr_blk)
        discard_q <= 1'b0;
      else if (overflow)
        discard_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Block buffer
  // ------------------------------------------------------------
  // (R5) (R6) Load on select, byte writes in place
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < BLK_BYTES; i++)
        block_buffer_q[i] <= 8'h00;
    end
    else if (wr_blk)
    begin
      for (int i = 0; i < BLK_BYTES; i++)
        block_buffer_q[i] <= slot_ok_d ? nv_q[slot_d][i] : 8'h00;
    end
    else if (overflow)
    begin
      // (R10) Drop the whole write
      for (int i = 0; i < BLK_BYTES; i++)
        block_buffer_q[i] <= slot_ok_q ? nv_q[slot_q][i] : 8'h00;
    end
    else if (wr_buf && !discard_q)
      block_buffer_q[cmd_addr_i[4:0]] <= cmd_wdata_i;
  end

  // ------------------------------------------------------------
  // Non-volatile storage and keys
  // ------------------------------------------------------------
  // (R11) (R12) No reset, no range check
  always_ff @(posedge sys_clk_i)
  begin
    // (R15) Commit block after valid checksum
    if (commit_ok)
    begin
      for (int i = 0; i < BLK_BYTES; i++)
        nv_q[slot_q][i] <= block_buffer_q[i];
    end
  end

  // (R18) Keys rewritten only in full access
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      unseal_key_q <= UNSEAL_KEY_RST;
      full_key_q <= FULL_KEY_RST;
    end
    else if (commit_ok && tgt_key_q)
    begin
      unseal_key_q <= buf_flat[31:0];
      full_key_q <= buf_flat[63:32];
    end
  end

  // Commit pulse
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      commit_o <= 1'b0;
    else
      commit_o <= commit_ok;
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb
  begin
    rd_mux = 8'h00;
    if (cmd_addr_i == CMD_CTL_LO)
      rd_mux = 8'h00;
    else if (cmd_addr_i == CMD_CTL_HI)
      rd_mux = {1'b0, full_access_flag_o, sealed_o, 5'h00};
    else if (cmd_addr_i == CMD_SUB)
      rd_mux = sealed_o ? 8'h00 : subclass_select_q;
    else if (cmd_addr_i == CMD_BLK)
      rd_mux = block_select_q;
    else if (in_buf(cmd_addr_i))
      rd_mux = block_buffer_q[cmd_addr_i[4:0]];
    else if (cmd_addr_i == CMD_CKS)
      rd_mux = block_checksum_q;
    else if (cmd_addr_i == CMD_DCTL)
      rd_mux = sealed_o ? 8'h00 : block_access_control_q;
    // (R3) Label length in every mode
    else if (cmd_addr_i == CMD_LEN)
      rd_mux = LABEL_LEN;
    // (R4) Label characters in every mode
    else if (cmd_addr_i >= CMD_LBL_LO && cmd_addr_i <= CMD_LBL_HI)
      rd_mux = LABEL_CHARS[8'd79 - 8'd8 * (cmd_addr_i - CMD_LBL_LO) -: 8];
  end

  // Registered read answer
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      cmd_rdata_o <= 8'h00;
      cmd_rvalid_o <= 1'b0;
    end
    else
    begin
      cmd_rvalid_o <= cmd_rd_i;
      if (cmd_rd_i)
        cmd_rdata_o <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_ctl_sealed_refused: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R2
    sealed_o && cmd_wr_i && cmd_addr_i == CMD_DCTL |=> $stable(block_access_control_q))
    else $error("control byte changed while sealed");
  a_sub_sealed_denied: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R17
    sealed_o && cmd_wr_i && cmd_addr_i == CMD_SUB |=> $stable(subclass_select_q))
    else $error("subclass changed while sealed");
  a_label_len_read: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R3
    cmd_rd_i && cmd_addr_i == CMD_LEN |=> cmd_rvalid_o && cmd_rdata_o == LABEL_LEN)
    else $error("label length read wrong");
  a_buf_byte_read: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R6
    cmd_rd_i && cmd_addr_i == CMD_BUF_LO |=> cmd_rdata_o == $past(block_buffer_q[0]))
    else $error("buffer byte read wrong");
  a_bad_cksum_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R26
    wr_cks && cmd_wdata_i != cks_expect |=> !commit_o)
    else $error("commit after wrong checksum");
  a_good_cksum_commit: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R7
    wr_cks && cmd_wdata_i == cks_expect && slot_ok_q && !discard_q && !sealed_o
    && !tgt_key_q |=> commit_o)
    else $error("valid checksum did not commit");
  a_vend_a_sealed: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R16
    commit_o |-> !($past(sealed_o) && $past(slot_q) == SLOT_VEND_A))
    else $error("vendor block A written while sealed");
  a_overflow_discard: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R10
    overflow && !wr_blk |=> discard_q ##0 !commit_o)
    else $error("overlong write not discarded");
  a_key_full_only: assert property (@(posedge sys_clk_i) disable iff (srst_i) // R18
    !full_q && wr_cks |=> $stable(unseal_key_q) && $stable(full_key_q))
    else $error("keys changed outside full access");
endmodule

// ==== verification/fba_host_model.sv ====
// Host processor model issuing byte command reads and writes.
// Assumes the device answers a read one cycle after its strobe.
`timescale 1ns/1ps
module fba_host_model
  import fba_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [7:0] cmd_rdata_i,
  input wire logic commit_i,
  output logic cmd_wr_o,
  output logic cmd_rd_o,
  output logic cmd_first_o,
  output logic [7:0] cmd_addr_o,
  output logic [7:0] cmd_wdata_o
);
  logic committed;
  logic [7:0] rd_byte;
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  // Idle bus at time zero
  initial
  begin
    cmd_wr_o = 1'b0;
    cmd_rd_o = 1'b0;
    cmd_first_o = 1'b0;
    cmd_addr_o = 8'hff;
    cmd_wdata_o = 8'hff;
    committed = 1'b0;
  end
  // One byte write; released lines show the inverse value
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic f);
    @(posedge sys_clk_i);
    #1;
    cmd_wr_o = 1'b1;
    cmd_first_o = f;
    cmd_addr_o = a;
    cmd_wdata_o = d;
    @(posedge sys_clk_i);
    #1;
    committed = commit_i;
    cmd_wr_o = 1'b0;
    cmd_first_o = 1'b0;
    cmd_addr_o = ~a;
    cmd_wdata_o = ~d;
  endtask
  // One byte read, data taken the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    #1;
    cmd_rd_o = 1'b1;
    cmd_addr_o = a;
    @(posedge sys_clk_i);
    #1;
    rd_byte = cmd_rdata_i;
    cmd_rd_o = 1'b0;
    cmd_addr_o = ~a;
  endtask
  task automatic sel(input logic [7:0] sub, input logic [7:0] blk);
    wr(CMD_SUB, sub, 1'b1);
    wr(CMD_BLK, blk, 1'b1);
  endtask
  function automatic logic [7:0] buf_addr(input int off);
    return CMD_BUF_LO + 8'(off % 32);
  endfunction
  task automatic ctl_word(input logic [15:0] w);
    wr(CMD_CTL_LO, w[7:0], 1'b1);
    wr(CMD_CTL_HI, w[15:8], 1'b1);
  endtask
  task automatic send_key(input logic [31:0] k);
    ctl_word({k[7:0], k[15:8]});
    ctl_word({k[23:16], k[31:24]});
  endtask
endmodule

// ==== verification/test_flash_block_access_security.sv ====
// Self-checking bench for the block access and security logic.
// Assumes the host model drives every command byte.
`timescale 1ns/1ps
module test_flash_block_access_security;
  import fba_pkg::*;
  logic sys_clk_i;
  logic srst_i;
  logic cmd_wr, cmd_rd, cmd_first, commit, sealed, full_access_flag, rvalid;
  logic [7:0] cmd_addr, cmd_wdata, cmd_rdata;
  int err_count, cmp_count, cyc;
  int vb[32], va[32], gn[32], bf[32], km[32];
  // ------------------------------------------------------------
  // Instances and clock
  // ------------------------------------------------------------
  fba_top u_fba_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cmd_wr_i(cmd_wr),
    .cmd_rd_i(cmd_rd), .cmd_first_i(cmd_first), .cmd_addr_i(cmd_addr),
    .cmd_wdata_i(cmd_wdata), .cmd_rdata_o(cmd_rdata), .cmd_rvalid_o(rvalid),
    .commit_o(commit), .sealed_o(sealed), .full_access_flag_o(full_access_flag));
  fba_host_model u_host (.sys_clk_i(sys_clk_i), .cmd_rdata_i(cmd_rdata),
    .commit_i(commit), .cmd_wr_o(cmd_wr), .cmd_rd_o(cmd_rd), .cmd_first_o(cmd_first),
    .cmd_addr_o(cmd_addr), .cmd_wdata_o(cmd_wdata));
  // 200 MHz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ------------------------------------------------------------
  // Model and helpers
  // ------------------------------------------------------------
  // Block checksum from the model bytes
  function automatic logic [7:0] cks(input int m[32]);
    int s;
    s = 0;
    foreach (m[i]) s += m[i];
    return 8'(255 - (s % 256));
  endfunction
  task automatic rnd(output int m[32]);
    foreach (m[i]) m[i] = $urandom % 256;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a);
    chk(n, u_host.rd_byte, e);
    // Valid pulse still stands when the data is taken
    chk("rvalid", {7'h00, rvalid}, 8'h01);
  endtask
  task automatic rd_blk(input string n, input int m[32]);
    for (int i = 0; i < 32; i++)
      rchk(n, u_host.buf_addr(i), 8'(m[i]));
  endtask
  // Buffer burst; bytes past 32 wrap the model index
  task automatic fill(input int m[32], input int n);
    for (int i = 0; i < n; i++)
      u_host.wr(u_host.buf_addr(i), 8'(m[i % 32]), i == 0);
  endtask
  task automatic cks_wr(input logic [7:0] v, input logic e);
    u_host.wr(CMD_CKS, v, 1'b1);
    chk("commit", {7'h00, u_host.committed}, {7'h00, e});
  endtask
  task automatic do_reset();
    @(posedge sys_clk_i);
    #1;
    srst_i = 1'b1;
    repeat (16) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      results();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    srst_i = 1'b1;
    err_count = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(80161));
    do_reset();
    chk("sealed", {7'h00, sealed}, 8'h01);
    chk("fas", {7'h00, full_access_flag}, 8'h01);
    rchk("status", CMD_CTL_HI, 8'h60);
    rchk("label_len", CMD_LEN, LABEL_LEN);
    for (int i = 0; i < 10; i++)
      rchk("label", CMD_LBL_LO + 8'(i), LABEL_CHARS[79 - 8 * i -: 8]);
    // Sealed refusals
    u_host.wr(CMD_DCTL, 8'h05, 1'b1);
    rchk("dctl_sealed", CMD_DCTL, 8'h00);
    u_host.wr(CMD_SUB, 8'h22, 1'b1);
    rchk("sub_sealed", CMD_SUB, 8'h00);
    // Sealed vendor B edit and commit
    rnd(vb);
    u_host.wr(CMD_BLK, VEND_SEL_B, 1'b1);
    fill(vb, 32);
    cks_wr(cks(vb), 1'b1);
    u_host.wr(CMD_BLK, VEND_SEL_B, 1'b1);
    rd_blk("vend_b", vb);
    // Broken and wrong key pairs, then the right one
    u_host.ctl_word({UNSEAL_KEY_RST[7:0], UNSEAL_KEY_RST[15:8]});
    u_host.ctl_word(16'h0000);
    u_host.ctl_word({UNSEAL_KEY_RST[23:16], UNSEAL_KEY_RST[31:24]});
    u_host.ctl_word(16'h0000);
    chk("sealed_gap", {7'h00, sealed}, 8'h01);
    u_host.send_key(32'h5a5ac3c3);
    chk("sealed_bad", {7'h00, sealed}, 8'h01);
    u_host.send_key(UNSEAL_KEY_RST);
    chk("unsealed", {7'h00, sealed}, 8'h00);
    rchk("status_uns", CMD_CTL_HI, 8'h40);
    // General access; vendor B as subclass 58 block 1
    u_host.wr(CMD_DCTL, DCTL_GENERAL, 1'b1);
    rchk("dctl", CMD_DCTL, DCTL_GENERAL);
    u_host.sel(SUB_VENDOR, 8'h01);
    rd_blk("vend_b_gen", vb);
    rnd(gn);
    u_host.sel(8'h22, 8'h00);
    fill(gn, 32);
    cks_wr(cks(gn), 1'b1);
    bf = gn;
    bf[5] = gn[5] ^ 8'h5a;
    u_host.wr(u_host.buf_addr(5), 8'(bf[5]), 1'b1);
    cks_wr(cks(bf) ^ 8'h01, 1'b0);
    u_host.sel(8'h22, 8'h00);
    rd_blk("gen_kept", gn);
    gn[5] = bf[5];
    u_host.wr(u_host.buf_addr(5), 8'(gn[5]), 1'b1);
    cks_wr(cks(gn), 1'b1);
    u_host.sel(8'h22, 8'h00);
    rd_blk("gen", gn);
    // Vendor mode while unsealed: block A
    rnd(va);
    u_host.wr(CMD_DCTL, 8'h01, 1'b1);
    u_host.wr(CMD_BLK, VEND_SEL_A, 1'b1);
    fill(va, 32);
    cks_wr(cks(va), 1'b1);
    // Storage across reset; sealed block A is read only
    do_reset();
    u_host.wr(CMD_BLK, VEND_SEL_A, 1'b1);
    rd_blk("vend_a", va);
    bf = va;
    bf[0] = va[0] ^ 1;
    u_host.wr(CMD_BUF_LO, 8'(bf[0]), 1'b1);
    cks_wr(cks(bf), 1'b0);
    // Overlong burst is discarded
    u_host.send_key(UNSEAL_KEY_RST);
    u_host.wr(CMD_DCTL, DCTL_GENERAL, 1'b1);
    u_host.sel(8'h22, 8'h00);
    rd_blk("gen_reset", gn);
    rnd(bf);
    fill(bf, 33);
    cks_wr(cks(gn), 1'b0);
    u_host.sel(8'h22, 8'h00);
    rd_blk("gen_disc", gn);
    // Key block refused while only unsealed
    rnd(km);
    km[0] = 8'h11;
    km[1] = 8'h22;
    km[2] = 8'h33;
    km[3] = 8'h44;
    u_host.sel(SUB_KEYS, 8'h00);
    fill(km, 32);
    cks_wr(cks(km), 1'b0);
    // Full access pair
    u_host.send_key(FULL_KEY_RST);
    chk("fas_full", {7'h00, full_access_flag}, 8'h00);
    rchk("status_full", CMD_CTL_HI, 8'h00);
    // Full access rewrites the keys; seal, then only the new key unseals
    u_host.sel(SUB_KEYS, 8'h00);
    fill(km, 32);
    cks_wr(cks(km), 1'b1);
    u_host.ctl_word(SEAL_SUBCMD);
    chk("resealed", {7'h00, sealed}, 8'h01);
    chk("fas_sealed", {7'h00, full_access_flag}, 8'h01);
    u_host.send_key(UNSEAL_KEY_RST);
    chk("old_key", {7'h00, sealed}, 8'h01);
    u_host.send_key(32'h44332211);
    chk("new_key", {7'h00, sealed}, 8'h00);
    results();
  end
endmodule
